// ---- design/pmuev_debounce.sv ----
// one input debouncer: level follows raw input after it stays changed for limit cycles
// assumes raw input synchronous to the clock
module pmuev_debounce
  import pmuev_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic raw_in,
  input wire logic enable_in,
  input wire pmuev_pkg::pmuev_cnt_t limit_in,
  output logic level_out
);
  pmuev_db_s st_reg;
  pmuev_db_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (!enable_in || limit_in == '0)
    begin
      st_next.level = raw_in;
      st_next.cnt = '0;
    end
    else if (raw_in == st_reg.level)
    begin
      st_next.cnt = '0;
    end
    else if (st_reg.cnt >= limit_in - 1'b1)
    begin
      st_next.level = raw_in;
      st_next.cnt = '0;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign level_out = st_reg.level;
endmodule

// ---- design/pmuev_params.svh ----
// constants of the system event register bank: offsets, fields, resets, timing
// assumes a 10 MHz core clock and a serial interface core outside that issues accesses
// Behaviour
// - auto-return clears page index after access ends
// - page bit 6 picks two-wire multiple-write mode
// - two-wire page 00x/01x maps low/high register ranges
// - four-wire page 000/001/010 maps three ranges
// - status reads show live signal values, inputs as debounced levels
// - ramp-ready low while converter ramps
// - overcurrent status follows current limit hit
// - thermal shutdown and warning status follow thresholds
// - power-good status follows output in range
// - status becoming active sets latched event flag, power-good on falling instead, ramp-ready excepted
// - unmasked set event asserts interrupt
// - writing back read value clears those flags
// - events during clearing write posted afterwards
// - first event register: undervoltage, five inputs
// - second event register: overcurrent, thermal, power loss
// - overcurrent mask suppresses interrupt and flag
// - other masks suppress only the interrupt
// - lock bit blocks writes 0xD0 to 0x14F
// - ramp step interval per converter selectable
// - debounce field selects input debounce time
// - polarity bit selects input active level
// - debounce applies only when input enables it
`ifndef PMUEV_PARAMS_SVH
`define PMUEV_PARAMS_SVH

`define PMUEV_OFS_STATUS_A 9'h050
`define PMUEV_OFS_STATUS_B 9'h051
`define PMUEV_OFS_EVENT_A 9'h052
`define PMUEV_OFS_EVENT_B 9'h053
`define PMUEV_OFS_MASK_A 9'h054
`define PMUEV_OFS_MASK_B 9'h055
`define PMUEV_OFS_CTRL 9'h056
`define PMUEV_LOCK_LO 9'h0d0
`define PMUEV_LOCK_HI 9'h14f

`define PMUEV_PAGE_RET_BIT 7
`define PMUEV_PAGE_WMODE_BIT 6
`define PMUEV_PAGE_WMASK 8'hc7
`define PMUEV_EVA_MASK 8'h5f
`define PMUEV_EVB_MASK 8'h3f
`define PMUEV_CTRL_LOCK_BIT 7

`define PMUEV_RST_PAGE 8'h00
`define PMUEV_RST_MASK_A 8'h00
`define PMUEV_RST_MASK_B 8'h00
`define PMUEV_RST_CTRL 8'h00

`define PMUEV_CLK_MHZ 10
`define PMUEV_RAMP_T0_NS 4000
`define PMUEV_RAMP_T1_NS 2000
`define PMUEV_RAMP_T2_NS 1000
`define PMUEV_RAMP_T3_NS 500
`define PMUEV_RAMP_CYC(ns) ((ns) * `PMUEV_CLK_MHZ / 1000)
`define PMUEV_DB_T1_US 100
`define PMUEV_DB_T2_US 1000
`define PMUEV_DB_T3_US 10000
`define PMUEV_DB_T4_US 50000
`define PMUEV_DB_T5_US 250000
`define PMUEV_DB_T6_US 500000
`define PMUEV_DB_T7_US 1000000
`define PMUEV_DB_CYC(us) ((us) * `PMUEV_CLK_MHZ)

`endif

// ---- design/pmuev_pkg.sv ----
// types of the system event register bank
// assumes pmuev_params.svh for the figures
package pmuev_pkg;
  localparam int PMUEV_CNT_W = 24;
  localparam int PMUEV_NUM_IN = 5;
  typedef logic [PMUEV_CNT_W-1:0] pmuev_cnt_t;
  typedef struct packed
  {
    logic level;
    pmuev_cnt_t cnt;
  } pmuev_db_s;
  typedef struct packed
  {
    logic [7:0] page_reg;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] ctrl;
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic [7:0] pend_a;
    logic [7:0] pend_b;
    logic [4:0] prev_act;
    logic prev_uv;
    logic [5:0] prev_sup;
    logic [7:0] rdata;
    logic rvalid;
    logic ext_wr;
    logic [8:0] ext_addr;
    logic [7:0] ext_wdata;
    logic irq_n;
    logic [1:0][5:0] ramp_cnt;
    logic [1:0] ramp_tick;
  } pmuev_state_s;
endpackage

// ---- design/pmuev_regs.sv ----
// system event register bank: page control, status, events, masks, lock, ramp and debounce
// assumes a serial interface core that issues one-cycle read/write strobes and an end strobe
`include "pmuev_params.svh"
module pmuev_regs
  import pmuev_pkg::*;
#(
  parameter int DB_CYC_1 = `PMUEV_DB_CYC(`PMUEV_DB_T1_US),
  parameter int DB_CYC_2 = `PMUEV_DB_CYC(`PMUEV_DB_T2_US),
  parameter int DB_CYC_3 = `PMUEV_DB_CYC(`PMUEV_DB_T3_US),
  parameter int DB_CYC_4 = `PMUEV_DB_CYC(`PMUEV_DB_T4_US),
  parameter int DB_CYC_5 = `PMUEV_DB_CYC(`PMUEV_DB_T5_US),
  parameter int DB_CYC_6 = `PMUEV_DB_CYC(`PMUEV_DB_T6_US),
  parameter int DB_CYC_7 = `PMUEV_DB_CYC(`PMUEV_DB_T7_US)
)
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic ACC_SPI_IN,
  input wire logic [7:0] ACC_ADDR_IN,
  input wire logic ACC_WR_IN,
  input wire logic ACC_RD_IN,
  input wire logic [7:0] ACC_WDATA_IN,
  input wire logic ACC_END_IN,
  input wire logic [4:0] INPUT_PIN_LEVEL_IN,
  input wire logic [4:0] INPUT_PIN_POLARITY_IN,
  input wire logic [4:0] INPUT_PIN_DEBOUNCE_EN_IN,
  input wire logic IO_SUPPLY_UNDERVOLTAGE_IN,
  input wire logic CONV_A_RAMPING_IN,
  input wire logic CONV_B_RAMPING_IN,
  input wire logic CONV_A_CURRENT_LIMIT_IN,
  input wire logic CONV_B_CURRENT_LIMIT_IN,
  input wire logic THERMAL_SHUTDOWN_FLAG_IN,
  input wire logic THERMAL_WARNING_FLAG_IN,
  input wire logic CONV_A_OUTPUT_OK_IN,
  input wire logic CONV_B_OUTPUT_OK_IN,
  output logic [7:0] ACC_RDATA_OUT,
  output logic ACC_RVALID_OUT,
  output logic EXT_WR_OUT,
  output logic [8:0] EXT_ADDR_OUT,
  output logic [7:0] EXT_WDATA_OUT,
  output logic WRITE_MODE_OUT,
  output logic LOCK_OUT,
  output logic CONV_A_RAMP_TICK_OUT,
  output logic CONV_B_RAMP_TICK_OUT,
  output logic IRQ_OUT_N
);
  import pmuev_pkg::*;

  localparam int CNT_MAX = (1 << PMUEV_CNT_W) - 1;

  if (DB_CYC_1 < 1 || DB_CYC_2 < DB_CYC_1 || DB_CYC_3 < DB_CYC_2 || DB_CYC_4 < DB_CYC_3 ||
      DB_CYC_5 < DB_CYC_4 || DB_CYC_6 < DB_CYC_5 || DB_CYC_7 < DB_CYC_6 || DB_CYC_7 > CNT_MAX)
  begin : g_bad_db
    $error("debounce cycle counts must rise and fit the counter");
  end

  localparam logic [5:0] RAMP_CYC_0 = 6'(`PMUEV_RAMP_CYC(`PMUEV_RAMP_T0_NS));
  localparam logic [5:0] RAMP_CYC_1 = 6'(`PMUEV_RAMP_CYC(`PMUEV_RAMP_T1_NS));
  localparam logic [5:0] RAMP_CYC_2 = 6'(`PMUEV_RAMP_CYC(`PMUEV_RAMP_T2_NS));
  localparam logic [5:0] RAMP_CYC_3 = 6'(`PMUEV_RAMP_CYC(`PMUEV_RAMP_T3_NS));

  pmuev_state_s st_reg;
  pmuev_state_s st_next;
  pmuev_cnt_t db_limit;
  logic [4:0] lvl;

  // shared debounce time picked by the control field
  always_comb
  begin
    case (st_reg.ctrl[2:0])
      3'h0: db_limit = '0;
      3'h1: db_limit = PMUEV_CNT_W'(DB_CYC_1);
      3'h2: db_limit = PMUEV_CNT_W'(DB_CYC_2);
      3'h3: db_limit = PMUEV_CNT_W'(DB_CYC_3);
      3'h4: db_limit = PMUEV_CNT_W'(DB_CYC_4);
      3'h5: db_limit = PMUEV_CNT_W'(DB_CYC_5);
      3'h6: db_limit = PMUEV_CNT_W'(DB_CYC_6);
      3'h7: db_limit = PMUEV_CNT_W'(DB_CYC_7);
      default: db_limit = '0;
    endcase
  end

  for (genvar i = 0; i < PMUEV_NUM_IN; i++)
  begin : g_db
    pmuev_debounce u_db
    (
      .CLK_IN(CLK_IN),
      .ARST_N_IN(ARST_N_IN),
      .raw_in(INPUT_PIN_LEVEL_IN[i]),
      .enable_in(INPUT_PIN_DEBOUNCE_EN_IN[i]),
      .limit_in(db_limit),
      .level_out(lvl[i])
    );
  end

  logic [8:0] full_addr;
  logic mapped;
  logic [4:0] act;
  logic [5:0] sup;
  logic [7:0] new_a;
  logic [7:0] new_b;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic clearing;
  logic [7:0] status_b;
  logic [1:0] ramping;
  logic [1:0] sel;
  logic [5:0] lim;

  always_comb
  begin
    st_next = st_reg;
    full_addr = '0;
    mapped = 1'b1;
    clr_a = '0;
    clr_b = '0;
    sel = '0;
    lim = '0;
    st_next.rvalid = 1'b0;
    st_next.ext_wr = 1'b0;

    // page index to register address
    if (ACC_SPI_IN)
    begin
      case (st_reg.page_reg[2:0])
        3'h0: full_addr = {2'b00, ACC_ADDR_IN[6:0]};
        3'h1: full_addr = {2'b01, ACC_ADDR_IN[6:0]};
        3'h2: full_addr = {2'b10, ACC_ADDR_IN[6:0]};
        default: mapped = 1'b0;
      endcase
    end
    else
    begin
      case (st_reg.page_reg[2:1])
        2'b00: full_addr = {1'b0, ACC_ADDR_IN};
        2'b01: full_addr = {2'b10, ACC_ADDR_IN[6:0]};
        default: mapped = 1'b0;
      endcase
    end

    // live status values
    status_b = {~CONV_B_RAMPING_IN, ~CONV_A_RAMPING_IN,
                CONV_B_CURRENT_LIMIT_IN, CONV_A_CURRENT_LIMIT_IN,
                THERMAL_SHUTDOWN_FLAG_IN, THERMAL_WARNING_FLAG_IN,
                CONV_B_OUTPUT_OK_IN, CONV_A_OUTPUT_OK_IN};

    // register writes
    if (ACC_WR_IN && mapped)
    begin
      if (full_addr[6:0] == 7'h00)
        st_next.page_reg = ACC_WDATA_IN & `PMUEV_PAGE_WMASK;
      else if (full_addr == `PMUEV_OFS_EVENT_A)
        clr_a = ACC_WDATA_IN & `PMUEV_EVA_MASK;
      else if (full_addr == `PMUEV_OFS_EVENT_B)
        clr_b = ACC_WDATA_IN & `PMUEV_EVB_MASK;
      else if (full_addr == `PMUEV_OFS_MASK_A)
        st_next.mask_a = ACC_WDATA_IN & `PMUEV_EVA_MASK;
      else if (full_addr == `PMUEV_OFS_MASK_B)
        st_next.mask_b = ACC_WDATA_IN & `PMUEV_EVB_MASK;
      else if (full_addr == `PMUEV_OFS_CTRL)
        st_next.ctrl = ACC_WDATA_IN;
      else if (!(st_reg.ctrl[`PMUEV_CTRL_LOCK_BIT] &&
                 full_addr >= `PMUEV_LOCK_LO && full_addr <= `PMUEV_LOCK_HI))
      begin
        st_next.ext_wr = 1'b1;
        st_next.ext_addr = full_addr;
        st_next.ext_wdata = ACC_WDATA_IN;
      end
    end
    clearing = ACC_WR_IN && mapped &&
               (full_addr == `PMUEV_OFS_EVENT_A || full_addr == `PMUEV_OFS_EVENT_B);

    // register reads, sampled at the strobe
    if (ACC_RD_IN)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = 8'h00;
      if (mapped)
      begin
        if (full_addr[6:0] == 7'h00)
          st_next.rdata = st_reg.page_reg;
        else if (full_addr == `PMUEV_OFS_STATUS_A)
          st_next.rdata = {3'h0, lvl};
        else if (full_addr == `PMUEV_OFS_STATUS_B)
          st_next.rdata = status_b;
        else if (full_addr == `PMUEV_OFS_EVENT_A)
          st_next.rdata = st_reg.ev_a;
        else if (full_addr == `PMUEV_OFS_EVENT_B)
          st_next.rdata = st_reg.ev_b;
        else if (full_addr == `PMUEV_OFS_MASK_A)
          st_next.rdata = st_reg.mask_a;
        else if (full_addr == `PMUEV_OFS_MASK_B)
          st_next.rdata = st_reg.mask_b;
        else if (full_addr == `PMUEV_OFS_CTRL)
          st_next.rdata = st_reg.ctrl;
      end
    end

    // event detection on status becoming active
    act = lvl ~^ INPUT_PIN_POLARITY_IN;
    sup = {CONV_B_CURRENT_LIMIT_IN, CONV_A_CURRENT_LIMIT_IN, THERMAL_SHUTDOWN_FLAG_IN,
           THERMAL_WARNING_FLAG_IN, ~CONV_B_OUTPUT_OK_IN, ~CONV_A_OUTPUT_OK_IN};
    new_a = {1'b0, IO_SUPPLY_UNDERVOLTAGE_IN & ~st_reg.prev_uv, 1'b0, act & ~st_reg.prev_act};
    new_b = {2'b00, sup & ~st_reg.prev_sup};
    new_b[5:4] = new_b[5:4] & ~st_reg.mask_b[5:4];
    st_next.prev_act = act;
    st_next.prev_uv = IO_SUPPLY_UNDERVOLTAGE_IN;
    st_next.prev_sup = sup;

    // latch, clear and hold back
    if (clearing)
    begin
      st_next.ev_a = (st_reg.ev_a & ~clr_a) | st_reg.pend_a;
      st_next.ev_b = (st_reg.ev_b & ~clr_b) | st_reg.pend_b;
      st_next.pend_a = new_a;
      st_next.pend_b = new_b;
    end
    else
    begin
      st_next.ev_a = st_reg.ev_a | st_reg.pend_a | new_a;
      st_next.ev_b = st_reg.ev_b | st_reg.pend_b | new_b;
      st_next.pend_a = '0;
      st_next.pend_b = '0;
    end

    // interrupt from unmasked flags
    st_next.irq_n = ~|{st_next.ev_a & ~st_next.mask_a,
                       st_next.ev_b & ~st_next.mask_b};

    // auto-return of the page index
    if (ACC_END_IN && st_next.page_reg[`PMUEV_PAGE_RET_BIT])
      st_next.page_reg[2:0] = 3'h0;

    // ramp step ticks per converter
    ramping = {CONV_B_RAMPING_IN, CONV_A_RAMPING_IN};
    for (int c = 0; c < 2; c++)
    begin
      sel = (c == 1) ? st_reg.ctrl[6:5] : st_reg.ctrl[4:3];
      case (sel)
        2'h0: lim = RAMP_CYC_0;
        2'h1: lim = RAMP_CYC_1;
        2'h2: lim = RAMP_CYC_2;
        2'h3: lim = RAMP_CYC_3;
        default: lim = RAMP_CYC_0;
      endcase
      st_next.ramp_tick[c] = 1'b0;
      if (!ramping[c])
        st_next.ramp_cnt[c] = '0;
      else if (st_reg.ramp_cnt[c] >= lim - 6'h01)
      begin
        st_next.ramp_cnt[c] = '0;
        st_next.ramp_tick[c] = 1'b1;
      end
      else
        st_next.ramp_cnt[c] = st_reg.ramp_cnt[c] + 6'h01;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      st_reg <= '0;
      st_reg.page_reg <= `PMUEV_RST_PAGE;
      st_reg.mask_a <= `PMUEV_RST_MASK_A;
      st_reg.mask_b <= `PMUEV_RST_MASK_B;
      st_reg.ctrl <= `PMUEV_RST_CTRL;
      st_reg.irq_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign ACC_RDATA_OUT = st_reg.rdata;
  assign ACC_RVALID_OUT = st_reg.rvalid;
  assign EXT_WR_OUT = st_reg.ext_wr;
  assign EXT_ADDR_OUT = st_reg.ext_addr;
  assign EXT_WDATA_OUT = st_reg.ext_wdata;
  assign WRITE_MODE_OUT = st_reg.page_reg[`PMUEV_PAGE_WMODE_BIT];
  assign LOCK_OUT = st_reg.ctrl[`PMUEV_CTRL_LOCK_BIT];
  assign CONV_A_RAMP_TICK_OUT = st_reg.ramp_tick[0];
  assign CONV_B_RAMP_TICK_OUT = st_reg.ramp_tick[1];
  assign IRQ_OUT_N = st_reg.irq_n;
endmodule

// ---- tb/pmu_system_event_regs_test.sv ----
// bench of the event register bank: host model, bound checker, scenario tasks
// assumes design, checker and host model compiled before this file
module pmu_system_event_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, spi, wr, rd, fin, uv, ra, rb, la, lb, ts, tw, oka, okb;
  logic [7:0] addr, wdata, rdata, ext_wdata;
  logic [4:0] lvl, pol, deb_en;
  logic [8:0] ext_addr;
  logic rvalid, ext_wr, wmode, lock, tick_a, tick_b, irq_n;
  int error_cnt = 0;
  int num_checks = 0;
  int iv[4] = '{40, 20, 10, 5};
  pmuev_regs #(.DB_CYC_1(3)) dut_u (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .ACC_SPI_IN(spi), .ACC_ADDR_IN(addr), .ACC_WR_IN(wr), .ACC_RD_IN(rd),
    .ACC_WDATA_IN(wdata), .ACC_END_IN(fin), .INPUT_PIN_LEVEL_IN(lvl), .INPUT_PIN_POLARITY_IN(pol),
    .INPUT_PIN_DEBOUNCE_EN_IN(deb_en), .IO_SUPPLY_UNDERVOLTAGE_IN(uv), .CONV_A_RAMPING_IN(ra), .CONV_B_RAMPING_IN(rb),
    .CONV_A_CURRENT_LIMIT_IN(la), .CONV_B_CURRENT_LIMIT_IN(lb), .THERMAL_SHUTDOWN_FLAG_IN(ts),
    .THERMAL_WARNING_FLAG_IN(tw), .CONV_A_OUTPUT_OK_IN(oka), .CONV_B_OUTPUT_OK_IN(okb), .ACC_RDATA_OUT(rdata),
    .ACC_RVALID_OUT(rvalid), .EXT_WR_OUT(ext_wr), .EXT_ADDR_OUT(ext_addr), .EXT_WDATA_OUT(ext_wdata),
    .WRITE_MODE_OUT(wmode), .LOCK_OUT(lock), .CONV_A_RAMP_TICK_OUT(tick_a), .CONV_B_RAMP_TICK_OUT(tick_b),
    .IRQ_OUT_N(irq_n));
  pmuev_host host_u (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .end_out(fin),
    .addr_out(addr), .wdata_out(wdata));
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host_u.rd(a, d, v);
    chk({8'h00, v}, 9'h001);
    chk({1'b0, d}, {1'b0, e});
  endtask
  task automatic t_reset();
    rdc(8'h54, 8'h00);
    rdc(8'h55, 8'h00);
    rdc(8'h56, 8'h00);
    rdc(8'h53, 8'h00);
    chk({8'h00, irq_n}, 9'h001);
    $display("reset test done");
  endtask
  task automatic t_status();
    lvl = 5'h15;
    ra = 1'b1;
    repeat (3) @(negedge clk);
    rdc(8'h50, 8'h15);
    rdc(8'h51, 8'h83);
    ra = 1'b0;
    lb = 1'b1;
    ts = 1'b1;
    rdc(8'h51, 8'heb);
    $display("status test done");
  endtask
  task automatic t_events();
    rdc(8'h52, 8'h15);
    rdc(8'h53, 8'h28);
    chk({8'h00, irq_n}, 9'h000);
    host_u.wr(8'h52, 8'h01);
    rdc(8'h52, 8'h14);
    host_u.wr(8'h52, 8'h00);
    rdc(8'h52, 8'h14);
    host_u.clear(8'h52);
    chk({8'h00, irq_n}, 9'h000);
    host_u.clear(8'h53);
    chk({8'h00, irq_n}, 9'h001);
    rdc(8'h53, 8'h00);
    $display("event test done");
  endtask
  task automatic t_mask();
    lb = 1'b0;
    ts = 1'b0;
    host_u.wr(8'h54, 8'hff);
    rdc(8'h54, 8'h5f);
    uv = 1'b1;
    repeat (3) @(negedge clk);
    rdc(8'h52, 8'h40);
    chk({8'h00, irq_n}, 9'h001);
    host_u.wr(8'h54, 8'h00);
    chk({8'h00, irq_n}, 9'h000);
    host_u.clear(8'h52);
    host_u.wr(8'h55, 8'h30);
    la = 1'b1;
    lb = 1'b1;
    repeat (3) @(negedge clk);
    rdc(8'h53, 8'h00);
    chk({8'h00, irq_n}, 9'h001);
    host_u.wr(8'h55, 8'h00);
    la = 1'b0;
    lb = 1'b0;
    repeat (2) @(negedge clk);
    la = 1'b1;
    lb = 1'b1;
    oka = 1'b0;
    tw = 1'b1;
    repeat (3) @(negedge clk);
    rdc(8'h53, 8'h35);
    host_u.clear(8'h53);
    $display("mask test done");
  endtask
  task automatic t_race();
    for (int k = 0; k < 2; k++)
    begin
      lvl[1] = 1'b0;
      repeat (3) @(negedge clk);
      fork
        host_u.wr(8'h52, 8'h02);
        begin
          repeat (k) @(negedge clk);
          lvl[1] = 1'b1;
        end
      join
      repeat (3) @(negedge clk);
      rdc(8'h52, 8'h02);
      chk({8'h00, irq_n}, 9'h000);
      host_u.wr(8'h52, 8'h02);
    end
    $display("race test done");
  endtask
  task automatic t_input();
    host_u.wr(8'h56, 8'h01);
    deb_en = 5'h08;
    lvl[3] = 1'b1;
    rdc(8'h50, 8'h17);
    repeat (2) @(negedge clk);
    rdc(8'h50, 8'h1f);
    rdc(8'h52, 8'h08);
    pol[0] = 1'b0;
    lvl[0] = 1'b0;
    repeat (3) @(negedge clk);
    rdc(8'h52, 8'h09);
    host_u.clear(8'h52);
    okb = 1'b0;
    repeat (3) @(negedge clk);
    rdc(8'h51, 8'hf4);
    rdc(8'h53, 8'h02);
    host_u.clear(8'h53);
    okb = 1'b1;
    host_u.wr(8'h56, 8'h00);
    $display("input test done");
  endtask
  task automatic t_page();
    spi = 1'b1;
    host_u.wr(8'h00, 8'h01);
    host_u.wr(8'h10, 8'h5a);
    chk({8'h00, ext_wr}, 9'h001);
    chk(ext_addr, 9'h090);
    host_u.wr(8'h00, 8'h82);
    host_u.wr(8'h05, 8'h11);
    chk(ext_addr, 9'h105);
    host_u.fin();
    rdc(8'h00, 8'h80);
    spi = 1'b0;
    host_u.wr(8'hd5, 8'h22);
    chk(ext_addr, 9'h0d5);
    host_u.wr(8'h00, 8'h43);
    chk({8'h00, wmode}, 9'h001);
    host_u.wr(8'h85, 8'h33);
    chk(ext_addr, 9'h105);
    host_u.wr(8'h00, 8'h00);
    host_u.wr(8'h56, 8'h80);
    chk({8'h00, lock}, 9'h001);
    host_u.wr(8'hd5, 8'h44);
    chk({8'h00, ext_wr}, 9'h000);
    host_u.wr(8'hcf, 8'h66);
    chk({8'h00, ext_wr}, 9'h001);
    chk(ext_addr, 9'h0cf);
    host_u.wr(8'h56, 8'h00);
    host_u.wr(8'hd5, 8'h55);
    chk({1'b0, ext_wdata}, 9'h055);
    $display("page test done");
  endtask
  task automatic gap(input logic b, input int e);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end
      while ((b ? tick_b : tick_a) !== 1'b1 && n < 200);
      if (n >= 200)
      begin
        error_cnt++;
        results();
      end
    end
    chk(n[8:0], e[8:0]);
  endtask
  task automatic t_ramp();
    ra = 1'b1;
    rb = 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      host_u.wr(8'h56, {1'b0, e[1:0], e[1:0], 3'b000});
      gap(1'b0, iv[e]);
      gap(1'b1, iv[e]);
    end
    ra = 1'b0;
    rb = 1'b0;
    $display("ramp test done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    {arst_n, spi, uv, ra, rb, la, lb, ts, tw} = 9'h000;
    {oka, okb} = 2'b11;
    lvl = 5'h00;
    pol = 5'h1f;
    deb_en = 5'h00;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_status();
    t_events();
    t_mask();
    t_race();
    t_input();
    t_page();
    t_ramp();
    results();
  end
endmodule

// ---- tb/pmuev_host.sv ----
// host model driving one-cycle register strobes on the falling edge
// assumes the bank answers a read in the cycle after the strobe
module pmuev_host
(
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic rd_out,
  output logic end_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    end_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // released bus shows inverted last value
  task automatic drop();
    wr_out = 1'b0;
    rd_out = 1'b0;
    end_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    drop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    d = rdata_in;
    v = rvalid_in;
    drop();
  endtask
  task automatic fin();
    @(negedge clk_in);
    end_out = 1'b1;
    @(negedge clk_in);
    drop();
  endtask
  task automatic clear(input logic [7:0] a);
    logic [7:0] d;
    logic v;
    rd(a, d, v);
    wr(a, d);
  endtask
endmodule

// ---- tb/pmuev_regs_checker.sv ----
// port checker of the event register bank, bound onto pmuev_regs
// assumes strobes and outputs are sampled on the rising clock edge
`include "pmuev_params.svh"
module pmuev_regs_checker
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic ACC_WR_IN,
  input wire logic ACC_RD_IN,
  input wire logic [7:0] ACC_WDATA_IN,
  input wire logic CONV_A_RAMPING_IN,
  input wire logic CONV_B_RAMPING_IN,
  input wire logic ACC_RVALID_OUT,
  input wire logic EXT_WR_OUT,
  input wire logic [8:0] EXT_ADDR_OUT,
  input wire logic [7:0] EXT_WDATA_OUT,
  input wire logic WRITE_MODE_OUT,
  input wire logic LOCK_OUT,
  input wire logic CONV_A_RAMP_TICK_OUT,
  input wire logic CONV_B_RAMP_TICK_OUT,
  input wire logic IRQ_OUT_N
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  rd_answer_a: assert property (ACC_RD_IN |=> ACC_RVALID_OUT) else $error("read not answered");
  rvalid_cause_a: assert property (ACC_RVALID_OUT |-> $past(ACC_RD_IN))
    else $error("stray read valid");
  ext_cause_a: assert property (EXT_WR_OUT |-> $past(ACC_WR_IN) && EXT_WDATA_OUT == $past(ACC_WDATA_IN))
    else $error("stray forwarded write");
  lock_block_a: assert property (EXT_WR_OUT && $past(LOCK_OUT) |->
    EXT_ADDR_OUT < `PMUEV_LOCK_LO || EXT_ADDR_OUT > `PMUEV_LOCK_HI) else $error("locked write forwarded");
  lock_write_a: assert property ($changed(LOCK_OUT) |-> $past(ACC_WR_IN))
    else $error("lock moved alone");
  wmode_write_a: assert property ($changed(WRITE_MODE_OUT) |-> $past(ACC_WR_IN))
    else $error("mode moved");
  irq_release_a: assert property ($rose(IRQ_OUT_N) |-> $past(ACC_WR_IN))
    else $error("irq dropped alone");
  tick_a_idle_a: assert property (!CONV_A_RAMPING_IN |=> !CONV_A_RAMP_TICK_OUT)
    else $error("idle tick a");
  tick_b_idle_a: assert property (!CONV_B_RAMPING_IN |=> !CONV_B_RAMP_TICK_OUT)
    else $error("idle tick b");
  read_c: cover property (ACC_RD_IN ##1 ACC_RVALID_OUT);
  fwd_c: cover property (EXT_WR_OUT);
  irq_c: cover property ($fell(IRQ_OUT_N));
  tick_c: cover property (CONV_B_RAMP_TICK_OUT);
endmodule
bind pmuev_regs pmuev_regs_checker chk_u (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .ACC_WR_IN(ACC_WR_IN),
  .ACC_RD_IN(ACC_RD_IN), .ACC_WDATA_IN(ACC_WDATA_IN), .CONV_A_RAMPING_IN(CONV_A_RAMPING_IN),
  .CONV_B_RAMPING_IN(CONV_B_RAMPING_IN), .ACC_RVALID_OUT(ACC_RVALID_OUT), .EXT_WR_OUT(EXT_WR_OUT),
  .EXT_ADDR_OUT(EXT_ADDR_OUT), .EXT_WDATA_OUT(EXT_WDATA_OUT), .WRITE_MODE_OUT(WRITE_MODE_OUT), .LOCK_OUT(LOCK_OUT),
  .CONV_A_RAMP_TICK_OUT(CONV_A_RAMP_TICK_OUT), .CONV_B_RAMP_TICK_OUT(CONV_B_RAMP_TICK_OUT), .IRQ_OUT_N(IRQ_OUT_N));
